// ### pkg/fsbd_pkg.sv
// Constants, types and field layout for the flash security byte decoder.
package fsbd_pkg;

  // ==========================================================================
  // Field positions inside the hardware security configuration byte.
  // ==========================================================================
  localparam int unsigned SPEED_BIT = 7;   // Double speed clock mode, zero selects six clocks.
  localparam int unsigned BOOT_BIT = 6;    // Boot vector select bit.
  localparam int unsigned OSCILLATOR_BIT = 5; // Startup oscillator select.
  localparam int unsigned RSVD_BIT = 4;    // Reserved, kept as stored.
  localparam int unsigned ERAM_BIT = 3;    // Expanded internal RAM inhibit, zero disables.
  localparam int unsigned LOCK2_BIT = 2;   // Code lock bit two.
  localparam int unsigned LOCK1_BIT = 1;   // Code lock bit one.
  localparam int unsigned LOCK0_BIT = 0;   // Code lock bit zero.

  // ==========================================================================
  // Values after reset and after a chip erase.
  // ==========================================================================
  localparam logic [7:0] SEC_BYTE_RESET = 8'hFB;   // Store content at reset: lock bit two programmed.
  localparam logic [7:0] SEC_BYTE_ERASED = 8'hFF;  // Inactive state written by a chip erase.
  localparam logic [7:0] LOCK_MASK = 8'h07;   // Lock bits that may only be programmed.
  localparam logic [7:0] READ_IDLE = 8'h00;   // Read data when no read is taken.

  // ==========================================================================
  // Reset vectors and clocks per instruction.
  // ==========================================================================
  localparam logic [15:0] BOOT_VEC_APP = 16'h0000;     // Start of user code.
  localparam logic [15:0] BOOT_VEC_LOADER = 16'hF800;  // Start of the boot loader.
  localparam logic [3:0] CLK_PER_INSTR_DBL = 4'h6;     // Double speed mode.
  localparam logic [3:0] CLK_PER_INSTR_STD = 4'hC;     // Standard mode.

  // Security levels, ordered from least to most restrictive.
  typedef enum logic [1:0] {SEC_L1, SEC_L2, SEC_L3, SEC_L4} fsbd_level_e;

  // Decoded reset-time configuration.
  typedef struct packed {
    logic double_speed;        // Double speed clock mode active.
    logic [3:0] clk_per_instr; // Clocks per instruction.
    logic [15:0] boot_addr;    // Reset vector.
    logic alt_oscillator_sel;  // Startup oscillator B selected.
    logic eram_en;             // Expanded internal RAM usable.
    fsbd_level_e level;        // Security level.
  } fsbd_cfg_s;

endpackage

// ### hw/fsbd_top.sv
// Security byte store, decode and code protection gates of the program flash.
module fsbd_top
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Core reset and core fetch status.
  input wire logic core_rst_active,
  input wire logic exec_from_external,
  input wire logic table_read_internal_req,
  input wire logic external_access_pin,
  // Boot API and in-system programming requests.
  input wire logic api_page_req,
  input wire logic isp_prog_req,
  // Parallel programmer port.
  input wire logic prog_mode,
  input wire logic prog_byte_wr,
  input wire logic [7:0] prog_byte_wdata,
  input wire logic prog_byte_rd,
  input wire logic prog_chip_erase,
  input wire logic prog_code_wr_req,
  input wire logic prog_code_vfy_req,
  output logic [7:0] prog_byte_rdata,
  // Decoded configuration, held from reset to reset.
  output fsbd_pkg::fsbd_cfg_s cfg,
  // Protection gates.
  output logic table_read_allow,
  output logic ext_access_effective,
  output logic ext_exec_allow,
  output logic prog_code_wr_grant,
  output logic prog_code_vfy_grant,
  output logic isp_prog_grant,
  output logic extra_page_sel,
  output logic flash_array_erase
);

  // ==========================================================================
  // Storage and captured state.
  // ==========================================================================
  logic [7:0] sec_byte_q;        // Nonvolatile security byte, modelled in flops.
  logic [7:0] sec_byte_d;        // Next content of the byte.
  fsbd_pkg::fsbd_cfg_s cfg_q;    // Configuration captured during core reset.
  fsbd_pkg::fsbd_cfg_s cfg_d;    // Decode of the present byte.
  logic ext_access_latched_q;    // External access pin caught during core reset.
  fsbd_pkg::fsbd_level_e live_level; // Level of the present byte, for the programmer.

  // Turn the three lock bits into a level; higher lock bits dominate.
  function automatic fsbd_pkg::fsbd_level_e fsbd_level_of(input logic [7:0] b);
    fsbd_pkg::fsbd_level_e lvl;
    lvl = fsbd_pkg::SEC_L1;
    if (!b[fsbd_pkg::LOCK2_BIT])
    begin
      lvl = fsbd_pkg::SEC_L4;
    end
    else if (!b[fsbd_pkg::LOCK1_BIT])
    begin
      lvl = fsbd_pkg::SEC_L3;
    end
    else if (!b[fsbd_pkg::LOCK0_BIT])
    begin
      lvl = fsbd_pkg::SEC_L2;
    end
    return lvl;
  endfunction

  // ==========================================================================
  // Programmer access to the byte.
  // ==========================================================================

  // The byte has no port toward the core; only the programmer mode can change it.
  // Lock bits are only ever programmed by a write, so a lower level needs an erase.
  always_comb
  begin
    sec_byte_d = sec_byte_q;
    if (prog_mode && prog_chip_erase)
    begin
      sec_byte_d = fsbd_pkg::SEC_BYTE_ERASED;
    end
    else if (prog_mode && prog_byte_wr)
    begin
      sec_byte_d = (prog_byte_wdata & ~fsbd_pkg::LOCK_MASK) | (prog_byte_wdata & sec_byte_q & fsbd_pkg::LOCK_MASK);
    end
  end

  // Store update.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sec_byte_q <= fsbd_pkg::SEC_BYTE_RESET;
    end
    else
    begin
      sec_byte_q <= sec_byte_d;
    end
  end

  // Registered read data; zero unless a programmer read is taken.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prog_byte_rdata <= fsbd_pkg::READ_IDLE;
    end
    else if (prog_mode && prog_byte_rd)
    begin
      prog_byte_rdata <= sec_byte_q;
    end
    else
    begin
      prog_byte_rdata <= fsbd_pkg::READ_IDLE;
    end
  end

  // The flash array is erased together with the byte.
  assign flash_array_erase = prog_mode && prog_chip_erase;

  // ==========================================================================
  // Decode of the byte.
  // ==========================================================================
  always_comb
  begin
    cfg_d.double_speed = !sec_byte_q[fsbd_pkg::SPEED_BIT];
    cfg_d.clk_per_instr = sec_byte_q[fsbd_pkg::SPEED_BIT] ? fsbd_pkg::CLK_PER_INSTR_STD : fsbd_pkg::CLK_PER_INSTR_DBL;
    cfg_d.boot_addr = sec_byte_q[fsbd_pkg::BOOT_BIT] ? fsbd_pkg::BOOT_VEC_LOADER : fsbd_pkg::BOOT_VEC_APP;
    cfg_d.alt_oscillator_sel = !sec_byte_q[fsbd_pkg::OSCILLATOR_BIT];
    cfg_d.eram_en = sec_byte_q[fsbd_pkg::ERAM_BIT];
    cfg_d.level = fsbd_level_of(sec_byte_q);
  end

  // The programmer sees the level of the byte as it stands now, so a chip erase
  // unlocks parallel programming at once, without waiting for a core reset.
  assign live_level = fsbd_level_of(sec_byte_q);

  // ==========================================================================
  // Reset-time capture.
  // ==========================================================================

  // Capture runs for every cycle of the core reset, so the last value before
  // release is the one that holds; a change to the byte afterwards has no effect
  // on the running core until its next reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_q.double_speed <= 1'b0;
      cfg_q.clk_per_instr <= fsbd_pkg::CLK_PER_INSTR_STD;
      cfg_q.boot_addr <= fsbd_pkg::BOOT_VEC_LOADER;
      cfg_q.alt_oscillator_sel <= 1'b0;
      cfg_q.eram_en <= 1'b1;
      cfg_q.level <= fsbd_pkg::SEC_L4;
    end
    else if (core_rst_active)
    begin
      cfg_q <= cfg_d;
    end
  end

  // The external access pin is caught while the core is held in reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_access_latched_q <= 1'b0;
    end
    else if (core_rst_active)
    begin
      ext_access_latched_q <= external_access_pin;
    end
  end

  assign cfg = cfg_q;

  // ==========================================================================
  // Protection gates toward the core.
  // ==========================================================================

  assign table_read_allow = table_read_internal_req && !(exec_from_external && cfg_q.level != fsbd_pkg::SEC_L1);

  assign ext_access_effective = (cfg_q.level == fsbd_pkg::SEC_L1) ? external_access_pin : ext_access_latched_q;

  assign ext_exec_allow = cfg_q.level != fsbd_pkg::SEC_L4;

  assign isp_prog_grant = isp_prog_req;

  // page only via API or programmer
  assign extra_page_sel = api_page_req || prog_mode;

  // ==========================================================================
  // Protection gates toward the programmer.
  // ==========================================================================

  assign prog_code_wr_grant = prog_mode && prog_code_wr_req && live_level == fsbd_pkg::SEC_L1;

  assign prog_code_vfy_grant = prog_mode && prog_code_vfy_req
    && (live_level == fsbd_pkg::SEC_L1 || live_level == fsbd_pkg::SEC_L2);

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_no_core_write;
    !prog_mode |=> sec_byte_q == $past(sec_byte_q);
  endproperty
  a_no_core_write: assert property (p_no_core_write) else $error("Byte changed outside programmer mode.");

  property p_page_sel;
    extra_page_sel |-> (api_page_req || prog_mode);
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("Extra page selected without API or programmer.");

  property p_speed;
    core_rst_active ##1 !core_rst_active |-> cfg.double_speed == !$past(sec_byte_q[fsbd_pkg::SPEED_BIT])
      && cfg.clk_per_instr == (cfg.double_speed ? 4'h6 : 4'hC);
  endproperty
  a_speed: assert property (p_speed) else $error("Speed mode does not match the byte.");

  property p_boot;
    core_rst_active ##1 !core_rst_active |->
      cfg.boot_addr == ($past(sec_byte_q[fsbd_pkg::BOOT_BIT]) ? 16'hF800 : 16'h0000);
  endproperty
  a_boot: assert property (p_boot) else $error("Boot vector does not match the byte.");

  property p_eram;
    core_rst_active ##1 !core_rst_active |-> cfg.eram_en == $past(sec_byte_q[fsbd_pkg::ERAM_BIT]);
  endproperty
  a_eram: assert property (p_eram) else $error("Expanded RAM enable does not match the byte.");

  property p_lock_sticky;
    prog_mode && !prog_chip_erase |=> (sec_byte_q & 8'h07) == (sec_byte_q & $past(sec_byte_q) & 8'h07);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("Lock bit unprogrammed without erase.");

  property p_level1_free;
    cfg.level == fsbd_pkg::SEC_L1 |-> table_read_allow == table_read_internal_req && ext_exec_allow
      && ext_access_effective == external_access_pin;
  endproperty
  a_level1_free: assert property (p_level1_free) else $error("Restriction applied at level one.");

  property p_level2_table;
    cfg.level != fsbd_pkg::SEC_L1 && exec_from_external |-> !table_read_allow;
  endproperty
  a_level2_table: assert property (p_level2_table) else $error("External table read reached internal code.");

  property p_isp;
    isp_prog_req |-> isp_prog_grant;
  endproperty
  a_isp: assert property (p_isp) else $error("In-system programming refused.");

  property p_verify;
    sec_byte_q[fsbd_pkg::LOCK1_BIT] == 1'b0 || sec_byte_q[fsbd_pkg::LOCK2_BIT] == 1'b0 |-> !prog_code_vfy_grant;
  endproperty
  a_verify: assert property (p_verify) else $error("Parallel verify granted at level three or four.");

  property p_ext_exec;
    cfg.level == fsbd_pkg::SEC_L4 |-> !ext_exec_allow && (!table_read_allow || !exec_from_external);
  endproperty
  a_ext_exec: assert property (p_ext_exec) else $error("External execution allowed at level four.");

  property p_erase;
    prog_mode && prog_chip_erase |=> sec_byte_q == 8'hFF ##1 prog_code_wr_grant == (prog_mode && prog_code_wr_req);
  endproperty
  a_erase: assert property (p_erase) else $error("Chip erase did not clear protection.");

  property p_hold;
    !core_rst_active && !$past(core_rst_active) |-> $stable(cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("Configuration changed outside core reset.");

  c_erase: cover property (prog_mode && prog_chip_erase ##1 prog_byte_rd ##1 prog_byte_rdata == 8'hFF);
  c_level2: cover property (cfg.level == fsbd_pkg::SEC_L2 && exec_from_external && table_read_internal_req);
  c_level4: cover property (core_rst_active ##1 !core_rst_active && cfg.level == fsbd_pkg::SEC_L4);
  c_verify: cover property (prog_code_vfy_grant);

endmodule

// ### verification/fsbd_prog_model.sv
// Parallel programmer model driving the security byte port.
module fsbd_prog_model
(
  // Clock.
  input wire logic clk,
  // Programmer side of the byte port.
  output logic prog_mode,
  output logic prog_byte_wr,
  output logic [7:0] prog_byte_wdata,
  output logic prog_byte_rd,
  output logic prog_chip_erase,
  input wire logic [7:0] prog_byte_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Idle state and access cycles
  // ==========================================================================
  // Outside programming mode with every strobe low.
  initial
  begin
    prog_mode = 1'b0;
    prog_byte_wr = 1'b0;
    prog_byte_wdata = 8'hA5;
    prog_byte_rd = 1'b0;
    prog_chip_erase = 1'b0;
  end

  task automatic set_mode(input logic on);
    @(negedge clk);
    prog_mode = on;
  endtask

  // Data is inverted after the cycle so a stale value never looks valid.
  // lock after verify
  task automatic wr_byte(input logic [7:0] v);
    @(negedge clk);
    prog_mode = 1'b1;
    prog_byte_wr = 1'b1;
    prog_byte_wdata = v;
    @(negedge clk);
    prog_byte_wr = 1'b0;
    prog_byte_wdata = ~v;
  endtask

  // Read data stands for one cycle after the taking edge, so sample it then.
  // parallel read
  task automatic rd_byte(output logic [7:0] v);
    @(negedge clk);
    prog_mode = 1'b1;
    prog_byte_rd = 1'b1;
    @(negedge clk);
    prog_byte_rd = 1'b0;
    v = prog_byte_rdata;
  endtask

  // Only a chip erase returns the lock bits to their inactive state.
  // erase clears protection
  task automatic erase_chip();
    @(negedge clk);
    prog_mode = 1'b1;
    prog_chip_erase = 1'b1;
    @(negedge clk);
    prog_chip_erase = 1'b0;
  endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the flash security byte decoder.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic core_rst_active = 1'b0;
  logic exec_from_external = 1'b1;  // External fetch is the case the gates restrict.
  logic table_read_internal_req = 1'b1;
  logic external_access_pin = 1'b0;
  logic api_page_req = 1'b0;
  logic isp_prog_req = 1'b1;
  logic prog_code_wr_req = 1'b1;
  logic prog_code_vfy_req = 1'b1;
  logic prog_mode, prog_byte_wr, prog_byte_rd, prog_chip_erase;
  logic [7:0] prog_byte_wdata, prog_byte_rdata, rd_v;
  fsbd_pkg::fsbd_cfg_s cfg;
  fsbd_pkg::fsbd_level_e exp_lvl;
  logic table_read_allow, ext_access_effective, ext_exec_allow, prog_code_wr_grant;
  logic prog_code_vfy_grant, isp_prog_grant, extra_page_sel, flash_array_erase;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_erase = 0;
  // Bytes covering every level, with don't-care lock bits both ways.
  logic [7:0] vals [7] = '{8'hFF, 8'h3E, 8'hFD, 8'hD1, 8'hFC, 8'h53, 8'hF8};
  localparam logic [24:0] CFG_RST = {1'b0, fsbd_pkg::CLK_PER_INSTR_STD,
    fsbd_pkg::BOOT_VEC_LOADER, 1'b0, 1'b1, fsbd_pkg::SEC_L4};

  fsbd_top i_fsbd_top (.clk(clk), .rst_b(rst_b), .core_rst_active(core_rst_active),
    .exec_from_external(exec_from_external), .table_read_internal_req(table_read_internal_req),
    .external_access_pin(external_access_pin), .api_page_req(api_page_req), .isp_prog_req(isp_prog_req),
    .prog_mode(prog_mode), .prog_byte_wr(prog_byte_wr), .prog_byte_wdata(prog_byte_wdata),
    .prog_byte_rd(prog_byte_rd), .prog_chip_erase(prog_chip_erase), .prog_code_wr_req(prog_code_wr_req),
    .prog_code_vfy_req(prog_code_vfy_req), .prog_byte_rdata(prog_byte_rdata), .cfg(cfg),
    .table_read_allow(table_read_allow), .ext_access_effective(ext_access_effective),
    .ext_exec_allow(ext_exec_allow),
    .prog_code_wr_grant(prog_code_wr_grant), .prog_code_vfy_grant(prog_code_vfy_grant),
    .isp_prog_grant(isp_prog_grant), .extra_page_sel(extra_page_sel), .flash_array_erase(flash_array_erase));

  fsbd_prog_model i_fsbd_prog_model (.clk(clk), .prog_mode(prog_mode), .prog_byte_wr(prog_byte_wr),
    .prog_byte_wdata(prog_byte_wdata), .prog_byte_rd(prog_byte_rd), .prog_chip_erase(prog_chip_erase),
    .prog_byte_rdata(prog_byte_rdata));

  // ==========================================================================
  // Clock, hang guard and helpers
  // ==========================================================================
  initial
  begin
    forever #5 clk = ~clk;
  end

  // The whole run needs under a hundred cycles; far beyond that means a hang.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // Every chip erase must reach the flash array for exactly one cycle.
  always @(posedge clk)
  begin
    if (flash_array_erase === 1'b1)
    begin
      n_erase <= n_erase + 1;
    end
  end

  // Level from the lock bits: zero means programmed, higher bits dominate.
  function automatic fsbd_pkg::fsbd_level_e lvl_of(input logic [7:0] v);
    return !v[2] ? fsbd_pkg::SEC_L4 : !v[1] ? fsbd_pkg::SEC_L3 : !v[0] ? fsbd_pkg::SEC_L2 : fsbd_pkg::SEC_L1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One core reset cycle with the pin high, then the pin drops.
  task automatic capture();
    @(negedge clk);
    core_rst_active = 1'b1;
    external_access_pin = 1'b1;
    @(negedge clk);
    core_rst_active = 1'b0;
    external_access_pin = 1'b0;
    #1;
  endtask

  task automatic end_sim();
    $display("Counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    chk(cfg, CFG_RST);
    chk(ext_exec_allow, 1'b0);
    chk(extra_page_sel, 1'b0);
    chk(flash_array_erase, 1'b0);
    i_fsbd_prog_model.rd_byte(rd_v);
    chk(rd_v, fsbd_pkg::SEC_BYTE_RESET);
    // A write cannot unprogram a lock bit; only erase can.
    i_fsbd_prog_model.erase_chip();
    i_fsbd_prog_model.wr_byte(8'hFB);
    i_fsbd_prog_model.wr_byte(8'hFF);
    i_fsbd_prog_model.rd_byte(rd_v);
    chk(rd_v, 8'hFB);
    @(negedge clk);
    chk(prog_byte_rdata, fsbd_pkg::READ_IDLE);
    // Every level and configuration bit, decoded through a core reset.
    foreach (vals[i])
    begin
      exp_lvl = lvl_of(vals[i]);
      i_fsbd_prog_model.erase_chip();
      chk(prog_code_wr_grant & prog_code_vfy_grant, 1'b1);
      i_fsbd_prog_model.wr_byte(vals[i]);
      i_fsbd_prog_model.rd_byte(rd_v);
      chk(rd_v, vals[i]);
      capture();
      chk(cfg.double_speed, !vals[i][7]);
      chk(cfg.clk_per_instr, vals[i][7] ? fsbd_pkg::CLK_PER_INSTR_STD : fsbd_pkg::CLK_PER_INSTR_DBL);
      chk(cfg.boot_addr, vals[i][6] ? fsbd_pkg::BOOT_VEC_LOADER : fsbd_pkg::BOOT_VEC_APP);
      chk(cfg.alt_oscillator_sel, !vals[i][5]);
      chk(cfg.eram_en, vals[i][3]);
      chk(cfg.level, exp_lvl);
      chk(table_read_allow, exp_lvl == fsbd_pkg::SEC_L1);
      chk(ext_access_effective, exp_lvl != fsbd_pkg::SEC_L1);
      chk(prog_code_wr_grant, exp_lvl == fsbd_pkg::SEC_L1);
      chk(prog_code_vfy_grant, exp_lvl <= fsbd_pkg::SEC_L2);
      chk(ext_exec_allow, exp_lvl != fsbd_pkg::SEC_L4);
      chk(isp_prog_grant, 1'b1);
    end
    // Erase outside core reset: decode holds, programmer gates see the live byte.
    i_fsbd_prog_model.erase_chip();
    @(negedge clk);
    chk(cfg.level, fsbd_pkg::SEC_L4);
    chk(prog_code_wr_grant, 1'b1);
    // Software page reached by the API with no programmer present.
    // Internal code may still table-read at level four; external execution stays off.
    i_fsbd_prog_model.set_mode(1'b0);
    api_page_req = 1'b1;
    exec_from_external = 1'b0;
    isp_prog_req = 1'b0;
    #1;
    chk(extra_page_sel, 1'b1);
    chk(prog_code_wr_grant, 1'b0);
    chk(table_read_allow, 1'b1);
    chk(ext_exec_allow, 1'b0);
    chk(isp_prog_grant, 1'b0);
    chk(n_erase, 9);
    end_sim();
  end
endmodule
